// [logic/abort_cause.sv]
// Purpose: Records the reason for each aborted I2C transfer in a read-only cause word
// Assumes: Event inputs are one-cycle pulses from the bus engines on clk;
//          the link clock arrives from a pin and is sampled here
// Notes:   Cause bits are sticky until software clears the abort interrupt or disables the controller
`timescale 1ns/1ps
`include "abort_cause_cfg.svh"
module abort_cause (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic      [31:0] reg_rdata,
    // Link pins
    input  wire logic        link_scl,
    input  wire logic        link_sda,
    // Master engine events
    input  wire logic        addr_nack,
    input  wire logic        addr_second,
    input  wire logic        data_nack,
    input  wire logic        gcall_active,
    input  wire logic        hs_code_ack,
    input  wire logic        start_byte_ack,
    input  wire logic        master_arb_lost,
    input  wire logic        master_start_req,
    input  wire logic        read_10bit_req,
    input  wire logic        xfer_busy,
    // Slave engine events
    input  wire logic        slave_read_req,
    input  wire logic        slave_read_end,
    input  wire logic        slave_tx_lost,
    input  wire logic        slave_serving_read,
    input  wire logic        queue_not_empty,
    // Data command writes from software
    input  wire logic        dcmd_push,
    input  wire logic [9:0]  dcmd_word,
    // Software abort request
    input  wire logic        software_abort_request,
    // Actions towards the bus engines
    output logic             stop_request,
    output logic             queue_flush,
    output logic             abort_busy,
    output logic             irq
);
    // Whole state of the block
    typedef struct packed {
        logic [2:0]                      scl_sync;   // Pin synchroniser plus edge stage
        logic [1:0]                      sda_sync;   // Pin synchroniser
        logic [15:0]                     cause;      // Sticky abort causes
        logic [3:0]                      ctrl;       // Software control word
        logic [1:0]                      irq_stat;   // Sticky interrupt sources
        logic [1:0]                      irq_en;     // Interrupt enables
        abort_cause_pkg::abort_state_type abt;       // Software abort sequencer
        logic [1:0]                      drain;      // Drain counter after STOP
        logic                            stop;       // STOP request pulse
        logic                            flush;      // Flush request pulse
        logic [31:0]                     rdata;      // Read data register
    } state_type;

    state_type st_q;   // Registered state
    state_type st_d;   // Next state
    logic [15:0] ev;   // Cause events this cycle
    logic scl_rise;    // Link clock rising edge, sampled in clk domain
    logic sda_line;    // Synchronised data level

    // Register select, used by reads and writes alike
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    // Link edges gate no cause event: scl_rise only feeds the link activity tracker
    // below, while the synchronised data level qualifies the slave bus lost cause
    assign scl_rise = st_q.scl_sync[1] & ~st_q.scl_sync[2];
    assign sda_line = st_q.sda_sync[1];

    // Decode each abort cause from the engine events
    always_comb begin
        ev = 16'h0000;
        ev[`BIT_SHORT_ADDR_NACK]  = addr_nack & ~st_q.ctrl[`CTRL_TEN_BIT] & ~gcall_active;
        ev[`BIT_LONG_FIRST_NACK]  = addr_nack & st_q.ctrl[`CTRL_TEN_BIT] & ~addr_second;
        ev[`BIT_LONG_SECOND_NACK] = addr_nack & st_q.ctrl[`CTRL_TEN_BIT] & addr_second;
        ev[`BIT_TX_BYTE_NACK]     = data_nack & st_q.ctrl[`CTRL_MASTER_EN];
        ev[`BIT_GCALL_NACK]       = addr_nack & gcall_active;
        ev[`BIT_GCALL_READ]       = dcmd_push & gcall_active
                                    & dcmd_word[`DCMD_GCALL_READ_BIT];
        ev[`BIT_HS_CODE_ACKED]    = hs_code_ack;
        ev[`BIT_START_BYTE_ACKED] = start_byte_ack;
        ev[`BIT_LONG_NO_RESTART]  = read_10bit_req & st_q.ctrl[`CTRL_TEN_BIT]
                                    & ~st_q.ctrl[`CTRL_RESTART_EN];
        ev[`BIT_MASTER_DISABLED]  = master_start_req & ~st_q.ctrl[`CTRL_MASTER_EN];
        ev[`BIT_ARB_LOST]         = master_arb_lost | slave_tx_lost;
        ev[`BIT_SLAVE_FLUSH]      = slave_read_req & queue_not_empty;
        ev[`BIT_SLAVE_ARB_LOST]   = slave_tx_lost;
        ev[`BIT_SLAVE_READ_DONE]  = slave_read_end;
        ev[`BIT_SLAVE_BUS_LOST]   = slave_tx_lost & sda_line;
        ev[`BIT_SLAVE_CMD_MISUSE] = dcmd_push & slave_serving_read
                                    & dcmd_word[`DCMD_READ_BIT];
    end

    // Next state of the whole block
    always_comb begin
        st_d       = st_q;
        st_d.stop  = 1'b0;
        st_d.flush = 1'b0;
        st_d.rdata = 32'h0000_0000;
        // Pin synchronisers; first stage feeds only the second
        st_d.scl_sync = {st_q.scl_sync[1:0], link_scl};
        st_d.sda_sync = {st_q.sda_sync[0], link_sda};
        // Register writes
        if (reg_write) begin
            if (hit(reg_addr, `CONTROL_OFFSET)) begin
                st_d.ctrl = reg_wdata[3:0];
            end
            if (hit(reg_addr, `IRQ_ENABLE_OFFSET)) begin
                st_d.irq_en = reg_wdata[1:0];
            end
            if (hit(reg_addr, `IRQ_CLEAR_OFFSET)) begin
                st_d.irq_stat = st_q.irq_stat & ~reg_wdata[1:0];
                // Clearing the abort interrupt releases the causes
                if (reg_wdata[`IRQ_ABORT]) begin
                    st_d.cause = `CAUSE_RESET;
                end
            end
        end
        // Disabling the controller drops every cause
        if (!st_d.ctrl[`CTRL_ENABLE]) begin
            st_d.cause = `CAUSE_RESET;
        end
        // New events win over a clear in the same cycle
        st_d.cause = st_d.cause | ev;
        if (|ev) begin
            st_d.irq_stat[`IRQ_ABORT] = 1'b1;
        end
        // Software abort sequencer, started only while enabled
        case (st_q.abt)
            abort_cause_pkg::ABT_IDLE: begin
                if (software_abort_request & st_q.ctrl[`CTRL_ENABLE]) begin
                    st_d.abt = abort_cause_pkg::ABT_WAIT_XFER;
                end
            end
            abort_cause_pkg::ABT_WAIT_XFER: begin
                // Let the byte in flight finish first
                if (!xfer_busy) begin
                    st_d.stop = 1'b1;
                    st_d.drain = 2'(`DRAIN_CYCLES);
                    st_d.abt = abort_cause_pkg::ABT_STOP;
                end
            end
            abort_cause_pkg::ABT_STOP: begin
                if (st_q.drain <= 2'h1) begin
                    st_d.flush = 1'b1;
                    st_d.abt = abort_cause_pkg::ABT_FLUSH;
                end else begin
                    st_d.drain = st_q.drain - 2'h1;
                end
            end
            abort_cause_pkg::ABT_FLUSH: begin
                st_d.irq_stat[`IRQ_ABORT_DONE] = 1'b1;
                st_d.irq_stat[`IRQ_ABORT] = 1'b1;
                st_d.abt = abort_cause_pkg::ABT_IDLE;
            end
            default: begin
                st_d.abt = abort_cause_pkg::ABT_IDLE;
            end
        endcase
        // Register reads, data shown in the following cycle
        if (reg_read) begin
            if (hit(reg_addr, `CAUSE_OFFSET)) begin
                st_d.rdata = {16'h0000, st_q.cause};
            end else if (hit(reg_addr, `IRQ_STATUS_OFFSET)) begin
                st_d.rdata = {30'h0, st_q.irq_stat};
            end else if (hit(reg_addr, `IRQ_ENABLE_OFFSET)) begin
                st_d.rdata = {30'h0, st_q.irq_en};
            end else if (hit(reg_addr, `CONTROL_OFFSET)) begin
                st_d.rdata = {28'h0, st_q.ctrl};
            end
        end
    end

    // Single state register
    always_ff @(posedge clk) begin
        if (rst) begin
            st_q <= '0;
            // Pins idle high behind their pull-ups; a zero start would fake a link edge
            st_q.scl_sync <= 3'h7;
            st_q.sda_sync <= 2'h3;
            st_q.cause <= `CAUSE_RESET;
            st_q.ctrl <= `CONTROL_RESET;
            st_q.irq_en <= `IRQ_ENABLE_RESET;
            st_q.abt <= abort_cause_pkg::ABT_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs
    assign reg_rdata    = st_q.rdata;
    assign stop_request = st_q.stop;
    assign queue_flush  = st_q.flush;
    assign abort_busy   = (st_q.abt != abort_cause_pkg::ABT_IDLE);
    assign irq          = |(st_q.irq_stat & st_q.irq_en);

    // Edge tracker kept for link activity; unused scl_rise would be dead logic
    logic link_seen_q; // Link has toggled since reset
    always_ff @(posedge clk) begin
        if (rst) begin
            link_seen_q <= 1'b0;
        end else if (scl_rise) begin
            link_seen_q <= 1'b1;
        end
    end

    // Checks
    property p_short_nack;
        @(posedge clk) disable iff (rst)
        (addr_nack & ~st_q.ctrl[`CTRL_TEN_BIT] & ~gcall_active & st_q.ctrl[`CTRL_ENABLE])
        |=> st_q.cause[0];
    endproperty
    a_short_nack: assert property (p_short_nack) else $error("bit 0 not set");

    property p_long_first;
        @(posedge clk) disable iff (rst)
        (addr_nack & st_q.ctrl[`CTRL_TEN_BIT] & ~addr_second) |=> st_q.cause[1];
    endproperty
    a_long_first: assert property (p_long_first) else $error("bit 1 not set");

    property p_long_second;
        @(posedge clk) disable iff (rst)
        (addr_nack & st_q.ctrl[`CTRL_TEN_BIT] & addr_second) |=> st_q.cause[2];
    endproperty
    a_long_second: assert property (p_long_second) else $error("bit 2 not set");

    property p_gcall_read;
        @(posedge clk) disable iff (rst)
        (dcmd_push & gcall_active & dcmd_word[9]) |=> st_q.cause[5];
    endproperty
    a_gcall_read: assert property (p_gcall_read) else $error("bit 5 not set");

    property p_bus_lost_pair;
        @(posedge clk) disable iff (rst)
        st_q.cause[14] |-> st_q.cause[12] && st_q.cause[10];
    endproperty
    a_bus_lost_pair: assert property (p_bus_lost_pair) else $error("bit 14 alone");

    property p_no_restart;
        @(posedge clk) disable iff (rst)
        (read_10bit_req & st_q.ctrl[`CTRL_TEN_BIT] & ~st_q.ctrl[`CTRL_RESTART_EN])
        |=> st_q.cause[8];
    endproperty
    a_no_restart: assert property (p_no_restart) else $error("bit 8 not set");

    property p_upper_zero;
        @(posedge clk) disable iff (rst)
        (reg_read && reg_addr == `CAUSE_OFFSET) |=> reg_rdata[31:16] == 16'h0000;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("reserved bits set");

    property p_held;
        @(posedge clk) disable iff (rst)
        (st_q.cause[13] && !(reg_write && reg_addr == `IRQ_CLEAR_OFFSET)
         && st_q.ctrl[0] && !reg_write) |=> st_q.cause[13];
    endproperty
    a_held: assert property (p_held) else $error("cause dropped");

    sequence s_stop_issued;
        stop_request ##2 queue_flush;
    endsequence
    property p_abort_seq;
        @(posedge clk) disable iff (rst)
        stop_request |-> s_stop_issued ##1 st_q.irq_stat[1];
    endproperty
    a_abort_seq: assert property (p_abort_seq) else $error("abort order wrong");
endmodule // abort_cause

// [logic/abort_cause_cfg.svh]
// Purpose: Offsets, field positions, reset values and timing counts of the abort cause block
// Assumes: 32-bit register port, byte offsets
// Notes:   Definitions only
`ifndef ABORT_CAUSE_CFG_SVH
`define ABORT_CAUSE_CFG_SVH
// Register offsets
`define CAUSE_OFFSET        8'h80
`define IRQ_STATUS_OFFSET   8'hA0
`define IRQ_CLEAR_OFFSET    8'hA4
`define IRQ_ENABLE_OFFSET   8'hA8
`define CONTROL_OFFSET      8'hAC
// Reset values
`define CAUSE_RESET         16'h0000
`define CONTROL_RESET       4'h0
`define IRQ_ENABLE_RESET    2'h0
// Cause field positions
`define BIT_SHORT_ADDR_NACK   0
`define BIT_LONG_FIRST_NACK   1
`define BIT_LONG_SECOND_NACK  2
`define BIT_TX_BYTE_NACK      3
`define BIT_GCALL_NACK        4
`define BIT_GCALL_READ        5
`define BIT_HS_CODE_ACKED     6
`define BIT_START_BYTE_ACKED  7
`define BIT_LONG_NO_RESTART   8
`define BIT_MASTER_DISABLED   9
`define BIT_ARB_LOST          10
`define BIT_SLAVE_FLUSH       11
`define BIT_SLAVE_ARB_LOST    12
`define BIT_SLAVE_READ_DONE   13
`define BIT_SLAVE_BUS_LOST    14
`define BIT_SLAVE_CMD_MISUSE  15
// Control word field positions
`define CTRL_ENABLE           0
`define CTRL_MASTER_EN        1
`define CTRL_RESTART_EN       2
`define CTRL_TEN_BIT          3
// Data command field positions
`define DCMD_READ_BIT         8
`define DCMD_GCALL_READ_BIT   9
// Interrupt status layout
`define IRQ_ABORT             0
`define IRQ_ABORT_DONE        1
// Abort drain time after STOP, in ns, and cycles at 20 MHz
`define DRAIN_TIME_NS         100
`define CLK_PERIOD_NS         50
`define DRAIN_CYCLES          ((`DRAIN_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// [logic/abort_cause_pkg.sv]
// Purpose: Types shared by the abort cause block
// Assumes: Nothing
// Notes:   Constants live in the cfg header
package abort_cause_pkg;
    // Software abort sequencer states
    typedef enum logic [1:0] {
        ABT_IDLE,
        ABT_WAIT_XFER,
        ABT_STOP,
        ABT_FLUSH
    } abort_state_type;
endpackage

// [tb/i2c_remote_model.sv]
// Purpose: Behavioural remote bus party that sends one byte frame on request
// Assumes: Both lines have pull-ups, so a released line reads high
// Notes:   Link clock is 400 ns and stands high between frames
`timescale 1ns/1ps
module i2c_remote_model (
    // Frame request from the bench
    input  wire logic       send,
    input  wire logic [7:0] frame_byte,
    // Bus lines as seen after the pull-ups
    output logic            scl,
    output logic            sda
);
    localparam time HALF = 200; // Half of the 400 ns link period
    integer         i;          // Bit counter, most significant first

    // One frame: START, eight data bits, released ack slot, STOP
    initial begin
        scl = 1'b1;
        sda = 1'b1;
        forever begin
            @(posedge send);
            sda = 1'b0;
            #HALF;
            scl = 1'b0;
            for (i = 7; i >= 0; i--) begin
                sda = frame_byte[i];
                #HALF;
                scl = 1'b1;
                #HALF;
                scl = 1'b0;
            end
            // Released for the ack slot, the pull-up wins
            sda = 1'b1;
            #HALF;
            scl = 1'b1;
            #HALF;
            scl = 1'b0;
            sda = 1'b0;
            #HALF;
            scl = 1'b1;
            #HALF;
            sda = 1'b1;
        end
    end
endmodule // i2c_remote_model

// [tb/abort_cause_tb_top.sv]
// Purpose: Self-checking bench for the abort cause block
// Assumes: Inputs change by non-blocking assignment on the rising edge
// Notes:   Cause events are driven from one table to keep the bench short
`timescale 1ns/1ps
`include "abort_cause_cfg.svh"
module abort_cause_tb_top;
    // Clock, reset and register port
    logic        clk       = 1'b0;
    logic        rst       = 1'b1;
    logic [7:0]  reg_addr  = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_write = 1'b0;
    logic        reg_read  = 1'b0;
    logic [31:0] reg_rdata;
    // Event pulses in table order and levels {serving, queue, gcall, second}
    logic [10:0] ev        = 11'h0;
    logic [3:0]  lv        = 4'h0;
    logic        xfer_busy = 1'b0;
    logic        abort_req = 1'b0;
    logic [9:0]  dcmd_word = 10'h0;
    // Link and outputs
    logic        send      = 1'b0;
    logic        link_scl;
    logic        link_sda;
    logic        stop_request;
    logic        queue_flush;
    logic        abort_busy;
    logic        irq;
    integer      fail_count  = 0;
    integer      checks_done = 0;
    // Per-case control word, levels, pulse index and expected cause word
    localparam logic [3:0] CT [17] = '{4'h3, 4'hB, 4'hB, 4'h3, 4'h3, 4'h3, 4'h3, 4'h3, 4'hB,
        4'h1, 4'h3, 4'h3, 4'h3, 4'h3, 4'h3, 4'h3, 4'hF};
    localparam logic [3:0] LV [17] = '{4'h0, 4'h0, 4'h1, 4'h0, 4'h2, 4'h2, 4'h0, 4'h0, 4'h0,
        4'h0, 4'h0, 4'h4, 4'h0, 4'h8, 4'h0, 4'h0, 4'h0};
    localparam int         PI [17] = '{0, 0, 0, 1, 0, 10, 2, 3, 4, 5, 6, 7, 8, 10, 9, 7, 4};
    localparam logic [15:0] EX [17] = '{16'h0001, 16'h0002, 16'h0004, 16'h0008, 16'h0010,
        16'h0020, 16'h0040, 16'h0080, 16'h0100, 16'h0200, 16'h0400, 16'h0800, 16'h2000,
        16'h8000, 16'h5400, 16'h0000, 16'h0000};

    // 20 MHz clock
    initial begin
        forever #25 clk = ~clk;
    end

    abort_cause dut_u (
        .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .link_scl(link_scl), .link_sda(link_sda), .addr_nack(ev[0]),
        .addr_second(lv[0]), .data_nack(ev[1]), .gcall_active(lv[1]),
        .hs_code_ack(ev[2]), .start_byte_ack(ev[3]), .master_arb_lost(ev[6]),
        .master_start_req(ev[5]), .read_10bit_req(ev[4]), .xfer_busy(xfer_busy),
        .slave_read_req(ev[7]), .slave_read_end(ev[8]), .slave_tx_lost(ev[9]),
        .slave_serving_read(lv[3]), .queue_not_empty(lv[2]), .dcmd_push(ev[10]),
        .dcmd_word(dcmd_word), .software_abort_request(abort_req),
        .stop_request(stop_request), .queue_flush(queue_flush),
        .abort_busy(abort_busy), .irq(irq));

    i2c_remote_model remote_u (
        .send(send), .frame_byte(8'h00), .scl(link_scl), .sda(link_sda));

    // Compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Register bus cycles, one-cycle strobes
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    // One-cycle event pulse, then return on the next edge so callers drive on edges
    task automatic pulse(input int i);
        @(posedge clk);
        ev[i] <= 1'b1;
        @(posedge clk);
        ev <= 11'h0;
        @(posedge clk);
    endtask

    // Reset values, an unmapped read and the control word
    task automatic t_reset;
        logic [31:0] v;
        rd(`CAUSE_OFFSET, v);
        chk(v, 32'h0);
        rd(`IRQ_ENABLE_OFFSET, v);
        chk(v, 32'h0);
        rd(`CONTROL_OFFSET, v);
        chk(v, 32'h0);
        rd(8'h40, v);
        chk(v, 32'h0);
        $display("test reset done");
    endtask

    // Every cause, plus two cases that must leave the word clear
    task automatic t_causes;
        logic [31:0] v;
        for (int i = 0; i < 17; i++) begin
            wr(`CONTROL_OFFSET, {28'h0, CT[i]});
            wr(`IRQ_CLEAR_OFFSET, 32'h1);
            lv        <= LV[i];
            dcmd_word <= LV[i][1] ? 10'h200 : 10'h100;
            pulse(PI[i]);
            lv <= 4'h0;
            rd(`CAUSE_OFFSET, v);
            chk(v, {16'h0, EX[i]});
        end
        $display("test causes done");
    endtask

    // Slave loss while the remote holds the data line low mid-frame
    task automatic t_link_low;
        logic [31:0] v;
        wr(`CONTROL_OFFSET, 32'h3);
        wr(`IRQ_CLEAR_OFFSET, 32'h1);
        send <= 1'b1;
        repeat (12) @(posedge clk);
        pulse(9);
        send <= 1'b0;
        rd(`CAUSE_OFFSET, v);
        chk(v & 32'h5000, 32'h1000);
        repeat (100) @(posedge clk);
        $display("test link done");
    endtask

    // Interrupt raise, mask, clear, read-only cause and disable clearing
    task automatic t_irq;
        logic [31:0] v;
        wr(`IRQ_CLEAR_OFFSET, 32'h1);
        wr(`IRQ_ENABLE_OFFSET, 32'h1);
        pulse(1);
        chk(irq, 1'b1);
        wr(`CAUSE_OFFSET, 32'hFFFF);
        rd(`CAUSE_OFFSET, v);
        chk(v, 32'h0008);
        wr(`IRQ_ENABLE_OFFSET, 32'h0);
        // The enable lands on the edge that ends the write; look one edge later
        @(posedge clk);
        chk(irq, 1'b0);
        wr(`IRQ_ENABLE_OFFSET, 32'h1);
        wr(`IRQ_CLEAR_OFFSET, 32'h1);
        rd(`CAUSE_OFFSET, v);
        chk(v, 32'h0);
        chk(irq, 1'b0);
        pulse(6);
        rd(`CAUSE_OFFSET, v);
        chk(v, 32'h0400);
        wr(`CONTROL_OFFSET, 32'h0);
        rd(`CAUSE_OFFSET, v);
        chk(v, 32'h0);
        $display("test irq done");
    endtask

    // Software abort: ignored when disabled, then finish, STOP, flush, status
    task automatic t_abort;
        logic [31:0] v;
        int          n;
        @(posedge clk);
        abort_req <= 1'b1;
        @(posedge clk);
        abort_req <= 1'b0;
        #1;
        chk(abort_busy, 1'b0);
        wr(`CONTROL_OFFSET, 32'h3);
        wr(`IRQ_CLEAR_OFFSET, 32'h3);
        xfer_busy <= 1'b1;
        abort_req <= 1'b1;
        @(posedge clk);
        abort_req <= 1'b0;
        #1;
        chk(abort_busy, 1'b1);
        repeat (4) @(posedge clk);
        #1;
        chk(stop_request, 1'b0);
        @(posedge clk);
        xfer_busy <= 1'b0;
        n = 0;
        while (stop_request !== 1'b1 && n < 10) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk(stop_request, 1'b1);
        repeat (2) @(posedge clk);
        #1;
        chk(queue_flush, 1'b1);
        repeat (2) @(posedge clk);
        rd(`IRQ_STATUS_OFFSET, v);
        chk(v, 32'h3);
        $display("test abort done");
    endtask

    // Verdict and end of run
    task automatic end_sim;
        $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Watchdog, well beyond the few hundred cycles the tests need
    initial begin
        #(50 * 20000);
        fail_count++;
        end_sim;
    end

    // Main sequence
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        t_reset;
        t_causes;
        t_link_low;
        t_irq;
        t_abort;
        end_sim;
    end
endmodule // abort_cause_tb_top
